// *** design/ffp_pkg.sv ***
package ffp_pkg;

  // ==========================================================================
  // Instruction codes
  localparam logic [7:0] OP_WR_CFG     = 8'h01;
  localparam logic [7:0] OP_PROG       = 8'h02;
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_RD_STATUS  = 8'h05;
  localparam logic [7:0] OP_FAST       = 8'h0B;
  localparam logic [7:0] OP_FAST4      = 8'h0C;
  localparam logic [7:0] OP_PROG4      = 8'h12;
  localparam logic [7:0] OP_READ4      = 8'h13;
  localparam logic [7:0] OP_ECC4       = 8'h18;
  localparam logic [7:0] OP_ECC        = 8'h19;
  localparam logic [7:0] OP_CLR_STATUS = 8'h30;
  localparam logic [7:0] OP_OTP_PROG   = 8'h42;
  localparam logic [7:0] OP_CLR_ALT    = 8'h82;
  localparam logic [7:0] OP_LOCK_CLR   = 8'hA6;
  localparam logic [7:0] OP_DUAL       = 8'hBB;
  localparam logic [7:0] OP_DUAL4      = 8'hBC;
  localparam logic [7:0] OP_PROT_PGM4  = 8'hE3;
  localparam logic [7:0] OP_PROT_ERS   = 8'hE4;
  localparam logic [7:0] OP_UNLOCK     = 8'hE9;
  localparam logic [7:0] OP_QUAD       = 8'hEB;
  localparam logic [7:0] OP_QUAD4      = 8'hEC;
  localparam logic [7:0] OP_PROT_PGM   = 8'hFD;

  // ==========================================================================
  // Field positions, counts and reset values
  localparam int         STAT_WIP_BIT      = 0;
  localparam int         STAT_PERR_BIT     = 6;
  localparam int         CFG_FREEZE_BIT    = 0;
  localparam int         SECTOR_SHIFT      = 18;
  localparam logic [3:0] CONT_MODE_NIB     = 4'hA;
  localparam logic [3:0] UNLOCK_BYTES      = 4'h8;
  localparam logic [3:0] CFG_BYTES         = 4'h2;
  localparam logic [3:0] ADDR_LAST_24      = 4'h2;
  localparam logic [3:0] ADDR_LAST_32      = 4'h3;
  localparam logic [31:0] BOOT_SECTOR_ADDR = 32'h0000_0000;

  // ==========================================================================
  // Timing
  localparam int UNLOCK_PENALTY_US  = 100;
  localparam int MCLK_MHZ           = 200;
  localparam int UNLOCK_PENALTY_CYC = UNLOCK_PENALTY_US * MCLK_MHZ;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {PH_IDLE, PH_INST, PH_ADDR, PH_MODE, PH_DUMMY, PH_DATA} ffp_phase_t;

  typedef struct packed {
    logic       all_quad_mode;
    logic       addr32;
    logic       read_protect;
    logic       password_mode;
    logic [3:0] latency;
  } ffp_cfg_t;

  typedef struct packed {
    logic write_in_progress_flag;
    logic p_err;
    logic persistent_protect_lock;
    logic otp_freeze;
  } ffp_stat_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic        aligned;
    logic [3:0]  ndata;
    logic [31:0] addr;
    logic [63:0] payload;
  } ffp_frame_t;

endpackage : ffp_pkg

// *** design/ffp_flash_cmd_frame.sv ***
`timescale 1ns/1ps
module ffp_flash_cmd_frame #(
  parameter int NUM_SECTORS   = 8,
  parameter int MEM_DEPTH     = 16,
  parameter int UNLOCK_CYCLES = ffp_pkg::UNLOCK_PENALTY_CYC
) (
  input  wire logic                  i_mclk,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_sck,
  input  wire logic                  i_cs_n,
  input  wire logic [3:0]            i_io,
  output logic [3:0]                 o_io,
  output logic [3:0]                 o_io_oe,
  input  wire ffp_pkg::ffp_cfg_t     i_cfg,
  input  wire logic [63:0]           i_password,
  output ffp_pkg::ffp_stat_t         o_status,
  output logic [NUM_SECTORS-1:0]     o_sector_protect
);
  import ffp_pkg::*;

  localparam int AW = $clog2(MEM_DEPTH);
  localparam int SW = $clog2(NUM_SECTORS);
  localparam int PW = $clog2(UNLOCK_CYCLES + 1);

  // ==========================================================================
  // Elaboration checks
  if (MEM_DEPTH < 2 || (MEM_DEPTH & (MEM_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("MEM_DEPTH must be a power of two");
  end
  if (NUM_SECTORS < 2 || NUM_SECTORS > 256 || SECTOR_SHIFT + SW > 32) begin : g_bad_sect
    $error("NUM_SECTORS out of range");
  end
  if (UNLOCK_CYCLES < 1) begin : g_bad_pen
    $error("UNLOCK_CYCLES must be positive");
  end

  // ==========================================================================
  // Decode helpers
  function automatic logic is_dual(input logic [7:0] op);
    is_dual = (op == OP_DUAL) || (op == OP_DUAL4);
  endfunction : is_dual

  function automatic logic is_quad(input logic [7:0] op);
    is_quad = (op == OP_QUAD) || (op == OP_QUAD4);
  endfunction : is_quad

  function automatic logic is_array_read(input logic [7:0] op);
    is_array_read = (op == OP_READ) || (op == OP_READ4) || (op == OP_FAST) ||
                    (op == OP_FAST4) || is_dual(op) || is_quad(op);
  endfunction : is_array_read

  function automatic logic is_ecc(input logic [7:0] op);
    is_ecc = (op == OP_ECC) || (op == OP_ECC4);
  endfunction : is_ecc

  function automatic logic is_prog(input logic [7:0] op);
    is_prog = (op == OP_PROG) || (op == OP_PROG4);
  endfunction : is_prog

  function automatic logic has_addr(input logic [7:0] op);
    has_addr = is_array_read(op) || is_ecc(op) || is_prog(op) ||
               (op == OP_PROT_PGM) || (op == OP_PROT_PGM4);
  endfunction : has_addr

  function automatic logic long_addr(input logic [7:0] op, input logic a32);
    long_addr = a32 || (op == OP_READ4) || (op == OP_FAST4) || (op == OP_DUAL4) ||
                (op == OP_QUAD4) || (op == OP_PROG4) || (op == OP_ECC4) || (op == OP_PROT_PGM4);
  endfunction : long_addr

  function automatic logic has_latency(input logic [7:0] op);
    has_latency = (op == OP_FAST) || (op == OP_FAST4) || is_dual(op) || is_quad(op);
  endfunction : has_latency

  function automatic logic [2:0] lanes(input logic [7:0] op, input ffp_phase_t ph, input logic qm);
    if (qm) begin
      lanes = 3'h4;
    end else if (ph == PH_INST) begin
      lanes = 3'h1;
    end else if (is_dual(op)) begin
      lanes = 3'h2;
    end else if (is_quad(op)) begin
      lanes = 3'h4;
    end else begin
      lanes = 3'h1;
    end
  endfunction : lanes

  // ==========================================================================
  // Link side: crossing of status and settings into the serial clock
  logic [9:0]  k_s1;
  logic [9:0]  k_s2;
  logic [9:0]  k_s3;
  logic [9:0]  k_st;
  ffp_cfg_t    kc;
  logic        k_wip;
  logic        k_perr;

  // Settings only move on serial clock edges, so a change needs four edges to land.
  always_ff @(posedge i_sck or negedge i_reset_n) begin
    if (!i_reset_n) begin
      k_s1 <= 10'h000;
      k_s2 <= 10'h000;
      k_s3 <= 10'h000;
      k_st <= 10'h000;
    end else begin
      k_s1 <= {i_cfg, o_status.write_in_progress_flag, o_status.p_err};
      k_s2 <= k_s1;
      k_s3 <= k_s2;
      if (k_s2 == k_s3) begin
        k_st <= k_s3;
      end
    end
  end

  assign kc     = ffp_cfg_t'(k_st[9:2]);
  assign k_wip  = k_st[1];
  assign k_perr = k_st[0];

  // ==========================================================================
  // Link side: frame state
  logic        frame_rst_n;
  ffp_phase_t  phase;
  ffp_phase_t  ph;
  ffp_phase_t  lat_ph;
  logic [2:0]  bitc;
  logic [3:0]  cnt;
  logic [7:0]  op;
  logic [7:0]  cur_op;
  logic [7:0]  sr;
  logic [7:0]  nsr;
  logic [31:0] addr;
  logic [2:0]  w;
  logic [3:0]  nsum;
  logic        bdone;
  logic [3:0]  alen_last;
  logic        cont;
  logic [7:0]  cont_op;
  logic        tog;
  ffp_frame_t  frm;
  logic [7:0]  mem [MEM_DEPTH];

  assign frame_rst_n = i_reset_n & ~i_cs_n;

  assign ph     = (phase == PH_IDLE) ? (cont ? PH_ADDR : PH_INST) : phase;
  assign cur_op = (phase == PH_IDLE) ? (cont ? cont_op : 8'h00) : op;
  assign w      = lanes(cur_op, ph, kc.all_quad_mode);
  assign nsum   = {1'b0, bitc} + {1'b0, w};
  assign bdone  = nsum[3];
  assign alen_last = long_addr(cur_op, kc.addr32) ? ADDR_LAST_32 : ADDR_LAST_24;
  assign lat_ph = (has_latency(cur_op) && kc.latency != 4'h0) ? PH_DUMMY : PH_DATA;

  // line 0 is the low bit of a group
  always_comb begin
    case (w)
      3'h1:    nsr = {sr[6:0], i_io[0]};
      3'h2:    nsr = {sr[5:0], i_io[1:0]};
      default: nsr = {sr[3:0], i_io[3:0]};
    endcase
  end

  always_ff @(posedge i_sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      phase <= PH_IDLE;
      bitc  <= 3'h0;
      cnt   <= 4'h0;
      op    <= 8'h00;
      sr    <= 8'h00;
      addr  <= 32'h0000_0000;
    end else begin
      phase <= ph;
      op    <= cur_op;
      sr    <= nsr;
      bitc  <= (ph == PH_DUMMY) ? bitc : nsum[2:0];
      case (ph)
        PH_INST: begin
          if (bdone) begin
            op    <= nsr;
            cnt   <= 4'h0;
            phase <= has_addr(nsr) ? PH_ADDR : PH_DATA;
          end
        end
        PH_ADDR: begin
          if (bdone) begin
            addr <= {addr[23:0], nsr};
            cnt  <= cnt + 4'h1;
            if (cnt == alen_last) begin
              cnt   <= 4'h0;
              phase <= (is_dual(cur_op) || is_quad(cur_op)) ? PH_MODE : lat_ph;
            end
          end
        end
        PH_MODE: begin
          if (bdone) begin
            phase <= lat_ph;
          end
        end
        PH_DUMMY: begin
          cnt <= cnt + 4'h1;
          if (cnt == kc.latency - 4'h1) begin
            cnt   <= 4'h0;
            phase <= PH_DATA;
          end
        end
        PH_DATA: begin
          if (bdone) begin
            addr <= addr + 32'h0000_0001;
          end
        end
        default: begin
          phase <= PH_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Link side: state that outlives a frame
  always_ff @(posedge i_sck or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cont    <= 1'b0;
      cont_op <= 8'h00;
      tog     <= 1'b0;
      frm     <= '0;
    end else begin
      frm.aligned <= (nsum[2:0] == 3'h0) || (ph == PH_DUMMY && bitc == 3'h0);
      if (phase == PH_IDLE) begin
        tog        <= ~tog;
        frm.ndata  <= 4'h0;
        frm.opcode <= cur_op;
      end
      if (ph == PH_INST && bdone) begin
        frm.opcode <= nsr;
      end
      if (ph == PH_ADDR && bdone) begin
        frm.addr <= {addr[23:0], nsr};
      end
      if (ph == PH_MODE && bdone) begin
        cont    <= nsr[7:4] == CONT_MODE_NIB;
        cont_op <= cur_op;
      end
      if (ph == PH_DATA && bdone) begin
        frm.payload <= {frm.payload[55:0], nsr};
        if (frm.ndata != 4'hF) begin
          frm.ndata <= frm.ndata + 4'h1;
        end
      end
    end
  end

  // Array content is not reset, like a real memory.
  always_ff @(posedge i_sck) begin
    if (ph == PH_DATA && bdone && is_prog(cur_op) && !k_wip) begin
      mem[addr[AW-1:0]] <= nsr;
    end
  end

  // ==========================================================================
  // Link side: read data
  logic [31:0] eff_addr;
  logic [7:0]  rd_byte;
  logic [7:0]  tx;
  logic        drive;

  assign eff_addr = kc.read_protect ? BOOT_SECTOR_ADDR : addr;

  always_comb begin
    rd_byte = 8'h00;
    if (cur_op == OP_RD_STATUS) begin
      rd_byte[STAT_WIP_BIT]  = k_wip;
      rd_byte[STAT_PERR_BIT] = k_perr;
    end else if (is_ecc(cur_op)) begin
      rd_byte = 8'(eff_addr[SECTOR_SHIFT +: SW]);
    end else begin
      rd_byte = mem[eff_addr[AW-1:0]];
    end
  end

  assign tx = rd_byte << bitc;
  // array read while busy is ignored
  assign drive = (ph == PH_DATA) && !(k_wip && is_array_read(cur_op)) &&
                 (is_array_read(cur_op) || is_ecc(cur_op) || cur_op == OP_RD_STATUS);

  // Data changes on the falling edge so the host samples it on the next rising edge.
  always_ff @(negedge i_sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      o_io    <= 4'h0;
      o_io_oe <= 4'h0;
    end else begin
      o_io    <= 4'h0;
      o_io_oe <= 4'h0;
      if (drive) begin
        case (w)
          3'h1: begin
            o_io[1]    <= tx[7];
            o_io_oe[1] <= 1'b1;
          end
          // dual data on lines 0 and 1
          3'h2: begin
            o_io[1:0]    <= tx[7:6];
            o_io_oe[1:0] <= 2'h3;
          end
          default: begin
            o_io    <= tx[7:4];
            o_io_oe <= 4'hF;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Core side: frame end detection
  logic [1:0]  m_s1;
  logic [1:0]  m_s2;
  logic [1:0]  m_s3;
  logic        cs_st;
  logic        seen_tog;
  logic        cs_rise;
  logic        frame_end;

  assign cs_rise   = m_s2[1] && m_s3[1] && !cs_st;
  assign frame_end = cs_rise && (m_s2[0] == m_s3[0]) && (m_s3[0] != seen_tog);

  // The frame summary is only read here after select rose and the serial clock stopped.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      m_s1     <= 2'h2;
      m_s2     <= 2'h2;
      m_s3     <= 2'h2;
      cs_st    <= 1'b1;
      seen_tog <= 1'b0;
    end else begin
      m_s1 <= {i_cs_n, tog};
      m_s2 <= m_s1;
      m_s3 <= m_s2;
      if (m_s2[1] == m_s3[1]) begin
        cs_st <= m_s3[1];
      end
      if (cs_rise) begin
        seen_tog <= m_s3[0];
      end
    end
  end

  // ==========================================================================
  // Core side: protection and status
  logic [PW-1:0] pen;
  logic          init_done;
  logic [SW-1:0] sect;
  logic          ok;

  assign sect = frm.addr[SECTOR_SHIFT +: SW];
  assign ok   = frame_end && frm.aligned && !o_status.write_in_progress_flag;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pen <= '0;
    end else if (ok && frm.opcode == OP_UNLOCK && pen == '0 && i_cfg.password_mode &&
                 frm.ndata == UNLOCK_BYTES && frm.payload != i_password) begin
      pen <= PW'(UNLOCK_CYCLES);
    end else if (pen != '0) begin
      pen <= pen - PW'(1);
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_status         <= '0;
      o_sector_protect <= '1;
      init_done        <= 1'b0;
    end else if (!init_done) begin
      init_done <= 1'b1;
      // reset value of the lock is the inverse of the mode: set when password mode is off
      o_status.persistent_protect_lock <= !i_cfg.password_mode;
    end else if (frame_end && frm.aligned) begin
      case (frm.opcode)
        OP_CLR_STATUS, OP_CLR_ALT: begin
          if (pen == '0) begin
            o_status.write_in_progress_flag <= 1'b0;
            o_status.p_err                  <= 1'b0;
          end
        end
        OP_UNLOCK: begin
          if (ok && pen == '0 && i_cfg.password_mode && frm.ndata == UNLOCK_BYTES) begin
            if (frm.payload == i_password) begin
              o_status.persistent_protect_lock <= 1'b1;
            end else begin
              o_status.p_err                  <= 1'b1;
              o_status.write_in_progress_flag <= 1'b1;
            end
          end
        end
        OP_LOCK_CLR: begin
          if (ok) begin
            o_status.persistent_protect_lock <= 1'b0;
          end
        end
        OP_PROT_PGM, OP_PROT_PGM4: begin
          if (ok && o_status.persistent_protect_lock && frm.ndata == 4'h0) begin
            o_sector_protect[sect] <= 1'b0;
          end else if (ok) begin
            o_status.p_err                  <= 1'b1;
            o_status.write_in_progress_flag <= 1'b1;
          end
        end
        OP_PROT_ERS: begin
          if (ok && o_status.persistent_protect_lock) begin
            o_sector_protect <= '1;
          end else if (ok) begin
            o_status.p_err                  <= 1'b1;
            o_status.write_in_progress_flag <= 1'b1;
          end
        end
        OP_WR_CFG: begin
          if (ok && frm.ndata == CFG_BYTES && frm.payload[CFG_FREEZE_BIT]) begin
            o_status.otp_freeze <= 1'b1;
          end
        end
        OP_OTP_PROG: begin
          if (ok && o_status.otp_freeze) begin
            o_status.p_err                  <= 1'b1;
            o_status.write_in_progress_flag <= 1'b1;
          end
        end
        default: begin
          o_status <= o_status;
        end
      endcase
    end
  end

endmodule : ffp_flash_cmd_frame

// *** verification/ffp_flash_cmd_frame_props.sv ***
`timescale 1ns/1ps
module ffp_flash_cmd_frame_props #(
  parameter int NUM_SECTORS = 8
) (
  input wire logic                   i_mclk,
  input wire logic                   i_reset_n,
  input wire logic                   i_cs_n,
  input wire ffp_pkg::ffp_cfg_t      i_cfg,
  input wire logic [3:0]             o_io_oe,
  input wire ffp_pkg::ffp_stat_t     o_status,
  input wire logic [NUM_SECTORS-1:0] o_sector_protect
);
  // ==========================================================================
  // Checks
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  sel_idle_a: assert property (i_cs_n |-> o_io_oe == 4'h0)
    else $error("lines driven while deselected");
  lane_set_a: assert property (o_io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("illegal set of driven lines");
  freeze_hold_a: assert property (!$fell(o_status.otp_freeze))
    else $error("freeze bit cleared");
  perr_busy_a: assert property ($rose(o_status.p_err) |-> o_status.write_in_progress_flag)
    else $error("error without busy");
  busy_hold_a: assert property ($rose(o_status.write_in_progress_flag) |-> o_status.write_in_progress_flag[*8])
    else $error("busy dropped early");
  lock_rise_a: assert property ($rose(o_status.persistent_protect_lock) |-> i_cfg.password_mode || !$past(i_reset_n, 2))
    else $error("lock set by command");
  pw_unlock_a: assert property ($rose(o_status.persistent_protect_lock) && i_cfg.password_mode |->
    !o_status.write_in_progress_flag && !o_status.p_err)
    else $error("lock set without clean unlock");
  sector_lock_a: assert property ($changed(o_sector_protect) |-> $past(o_status.persistent_protect_lock))
    else $error("sector bits changed while locked");
endmodule : ffp_flash_cmd_frame_props

bind ffp_flash_cmd_frame ffp_flash_cmd_frame_props #(
  .NUM_SECTORS(NUM_SECTORS)
) ffp_flash_cmd_frame_props_inst (
  .i_mclk          (i_mclk),
  .i_reset_n       (i_reset_n),
  .i_cs_n          (i_cs_n),
  .i_cfg           (i_cfg),
  .o_io_oe         (o_io_oe),
  .o_status        (o_status),
  .o_sector_protect(o_sector_protect)
);

// *** verification/ffp_host_model.sv ***
`timescale 1ns/1ps
module ffp_host_model (
  input  wire logic [3:0] i_dev_io,
  input  wire logic [3:0] i_dev_oe,
  output logic            o_sck,
  output logic            o_cs_n,
  output logic [3:0]      o_io
);
  logic [3:0] hv;
  logic [3:0] hoe;
  logic [3:0] flip;
  // Released lines toggle, so a stale level never reads as data.
  assign o_io = (i_dev_oe & i_dev_io) | (~i_dev_oe & ((hoe & hv) | (~hoe & flip)));
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    hv = 4'h0;
    hoe = 4'h0;
    flip = 4'h5;
  end
  always @(o_sck) flip <= ~flip;
  // Select low before the first clock; the clock runs only in frames.
  // Line 0 takes the low bit of each group, groups high first.
  task automatic go(input logic [63:0] v, input int n, input int w, input logic d, output logic [63:0] r);
    r = 64'h0;
    o_cs_n = 1'b0;
    for (int i = n; i > 0; i -= w) begin
      for (int j = 0; j < w; j++)
        hv[j] = v[i - w + j];
      hoe = d ? 4'(2 ** w - 1) : 4'h0;
      #40;
      r = (r << w) | 64'(w == 1 && !d ? o_io[1] : o_io & 4'(2 ** w - 1));
      o_sck = 1'b1;
      #40;
      o_sck = 1'b0;
    end
  endtask : go
  task automatic fin;
    #40;
    o_cs_n = 1'b1;
    hoe = 4'h0;
    #100;
  endtask : fin
endmodule : ffp_host_model

// *** verification/ffp_flash_cmd_frame_tb.sv ***
`timescale 1ns/1ps
module ffp_flash_cmd_frame_tb;
  import ffp_pkg::*;
  logic        i_mclk;
  logic        i_reset_n;
  logic        sck;
  logic        cs_n;
  logic        oe_seen;
  logic [3:0]  io;
  logic [3:0]  dio;
  logic [3:0]  doe;
  logic [7:0]  sp;
  logic [63:0] r;
  logic [63:0] pw;
  ffp_cfg_t    cfg;
  ffp_stat_t   st;
  int          fail_count;
  int          num_checks;

  ffp_flash_cmd_frame #(
    .UNLOCK_CYCLES(400)
  ) ffp_flash_cmd_frame_inst (
    .i_mclk          (i_mclk),
    .i_reset_n       (i_reset_n),
    .i_sck           (sck),
    .i_cs_n          (cs_n),
    .i_io            (io),
    .o_io            (dio),
    .o_io_oe         (doe),
    .i_cfg           (cfg),
    .i_password      (pw),
    .o_status        (st),
    .o_sector_protect(sp)
  );
  ffp_host_model ffp_host_model_inst (
    .i_dev_io(dio),
    .i_dev_oe(doe),
    .o_sck   (sck),
    .o_cs_n  (cs_n),
    .o_io    (io)
  );

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) oe_seen <= oe_seen | (|doe);

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic x(input logic [63:0] v, input int n, input int w, input logic d);
    ffp_host_model_inst.go(v, n, w, d, r);
  endtask : x
  task automatic cmd(input logic [7:0] op, input logic [63:0] v, input int n);
    x(op, 8, 1, 1);
    x(v, n, 1, 1);
    ffp_host_model_inst.fin();
  endtask : cmd
  task automatic setcfg(input ffp_cfg_t c);
    @(negedge i_mclk);
    cfg = c;
    cmd(8'h00, 0, 0);
  endtask : setcfg
  task automatic rd(input logic [7:0] op, input logic ni, input logic [31:0] a, input int w, input int mb);
    int an;
    int lat;
    an = (op inside {OP_READ4, OP_FAST4, OP_DUAL4, OP_QUAD4, OP_ECC4} || cfg.addr32) ? 32 : 24;
    lat = (op inside {OP_FAST, OP_FAST4, OP_DUAL, OP_DUAL4, OP_QUAD, OP_QUAD4}) ? int'(cfg.latency) : 0;
    if (!ni) x(op, 8, cfg.all_quad_mode ? 4 : 1, 1);
    x(a, an, w, 1);
    if (mb >= 0) x(mb, 8, w, 1);
    x(0, lat * w, w, 0);
    x(0, 16, w, 0);
    ffp_host_model_inst.fin();
  endtask : rd

  // ==========================================================================
  // Scenarios
  task automatic t_reads;
    logic [7:0] ops [8] = '{OP_READ, OP_FAST, OP_DUAL, OP_QUAD, OP_READ4, OP_FAST4, OP_DUAL4, OP_QUAD4};
    int         ws [8] = '{1, 1, 2, 4, 1, 1, 2, 4};
    cmd(OP_PROG, 48'h000005_A53C96, 48);
    foreach (ops[i]) begin
      rd(ops[i], 0, 5, ws[i], ws[i] > 1 ? 0 : -1);
      chk(r[15:0], 16'hA53C);
    end
    rd(OP_QUAD, 0, 5, 4, 8'hA0);
    chk(r[15:0], 16'hA53C);
    rd(OP_QUAD, 1, 6, 4, 0);
    chk(r[15:0], 16'h3C96);
  endtask : t_reads
  task automatic t_unlock;
    cmd(OP_UNLOCK, pw ^ 64'h1, 64);
    chk(st, 4'hC);
    cmd(OP_CLR_STATUS, 0, 0);
    chk(st, 4'hC);
    x(OP_RD_STATUS, 8, 1, 1);
    x(0, 8, 1, 0);
    ffp_host_model_inst.fin();
    chk(r[7:0], 8'h41);
    cmd(OP_UNLOCK, pw, 64);
    chk(st, 4'hC);
    oe_seen = 1'b0;
    rd(OP_READ, 0, 5, 1, -1);
    chk(oe_seen, 0);
    cmd(OP_CLR_STATUS, 0, 0);
    chk(st, 4'h0);
    cmd(OP_UNLOCK, pw, 64);
    chk(st, 4'h2);
  endtask : t_unlock
  task automatic t_prot;
    x(OP_LOCK_CLR, 8, 1, 1);
    x(0, 1, 1, 1);
    ffp_host_model_inst.fin();
    chk(st, 4'h2);
    cmd(OP_PROT_PGM4, 32'h000C_0000, 32);
    chk(sp, 8'hF7);
    cmd(OP_LOCK_CLR, 0, 0);
    cmd(OP_PROT_PGM, 24'h040000, 24);
    chk({st, sp}, 12'hCF7);
    cmd(OP_CLR_ALT, 0, 0);
    cmd(OP_WR_CFG, 16'h0001, 16);
    cmd(OP_OTP_PROG, 24'h000000, 24);
    chk(st, 4'hD);
    cmd(OP_CLR_STATUS, 0, 0);
    cmd(OP_WR_CFG, 16'h0000, 16);
    chk(st, 4'h1);
    cmd(OP_PROT_ERS, 0, 0);
    chk({st, sp}, 12'hDF7);
    cmd(OP_CLR_STATUS, 0, 0);
    cmd(OP_UNLOCK, pw, 64);
    cmd(OP_PROT_ERS, 0, 0);
    chk({st, sp}, 12'h3FF);
    for (int p = 0; p < 2; p++) begin
      setcfg(p ? 8'h32 : 8'h12);
      rd(p ? OP_ECC4 : OP_ECC, 0, 32'h000C_0000, 1, -1);
      chk(r[15:8], p ? 8'h00 : 8'h03);
    end
  endtask : t_prot
  task automatic t_quad;
    setcfg(8'hD2);
    rd(OP_READ, 0, 5, 4, -1);
    chk(r[15:0], 16'hA53C);
    rd(OP_FAST, 0, 6, 4, -1);
    chk(r[15:0], 16'h3C96);
  endtask : t_quad

  task automatic print_verdict;
    $display("Checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #500000;
    fail_count++;
    print_verdict();
  end
  initial begin
    i_reset_n = 1'b0;
    cfg = 8'h12;
    pw = 64'h0123_4567_89AB_CDEF;
    oe_seen = 1'b0;
    fail_count = 0;
    num_checks = 0;
    repeat (5) @(negedge i_mclk);
    i_reset_n = 1'b1;
    repeat (2) @(negedge i_mclk);
    chk({st, sp}, 12'h0FF);
    setcfg(8'h12);
    t_reads();
    t_unlock();
    t_prot();
    t_quad();
    print_verdict();
  end
endmodule : ffp_flash_cmd_frame_tb
